// ===== verilog/cts_pkg.sv
// constants and types for the transceiver supervisor
package cts_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CNT_W         = 16;
    localparam logic [15:0] FILTER_CYC        = 16'h0040;
    localparam logic [15:0] WAKE_TIMEOUT_CYC  = 16'h0fa0;
    localparam logic [15:0] CLAMP_DETECT_CYC  = 16'h0028;
    localparam logic [15:0] DOMINANT_TO_CYC   = 16'h07d0;
    localparam int unsigned TXD_RECOVER_NS    = 4000;
    localparam logic [15:0] TXD_RECOVER_CYC   =
        16'((TXD_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CTS_UNPOWERED,
        CTS_STANDBY,
        CTS_NORMAL
    } cts_mode_t;

    typedef enum logic [1:0] {
        CTS_W_IDLE,
        CTS_W_DOM1,
        CTS_W_REC
    } cts_wake_t;

    typedef struct packed {
        cts_mode_t mode;
        logic      silent;
        logic      dom_timeout;
        logic      overtemp;
        logic      wake_pending;
    } cts_status_t;

endpackage : cts_pkg

// ===== verilog/cts_supervisor.sv
// supervisory logic: mode control, wake filter, fail-safe gating
`timescale 1ns/1ns
`default_nettype none
module cts_supervisor (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          ce_i,
    // controller side
    input  wire logic          txd_i,
    input  wire logic          standby_request_in_i,
    output logic               rxd_o,
    // analogue monitors
    input  wire logic          vcc_uv_i,
    input  wire logic          io_supply_uv_i,
    input  wire logic          overtemp_i,
    input  wire logic          bus_level_comparator_i,
    input  wire logic          wake_comparator_i,
    input  wire logic          rxd_pin_i,
    // driver stage controls
    output logic               drv_enable_o,
    output logic               drv_dominant_o,
    output logic               hs_comp_enable_o,
    output logic               wake_comp_enable_o,
    output cts_pkg::cts_status_t status_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cts_pkg::cts_mode_t mode;
    cts_pkg::cts_mode_t next_mode;
    cts_pkg::cts_wake_t wstate;
    logic               uv;
    logic               filt_dom;
    logic [15:0]        filt_cnt;
    logic               filt_rise;
    logic               filt_fall;
    logic [15:0]        wake_cnt;
    logic               wake_pending;
    logic               dom_to;
    logic [15:0]        txd_low_cnt;
    logic [15:0]        txd_high_cnt;
    logic               ot_latch;
    logic               silent;
    logic [15:0]        clamp_cnt;
    logic               next_drv_en;

    assign uv = vcc_uv_i | io_supply_uv_i;

    // ------------------------------------------------------------
    // operating mode
    // ------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        if (uv) begin
            next_mode = cts_pkg::CTS_UNPOWERED;
        end else begin
            unique case (mode)
                cts_pkg::CTS_UNPOWERED,
                cts_pkg::CTS_STANDBY: begin
                    if (!standby_request_in_i && txd_i) begin
                        next_mode = cts_pkg::CTS_NORMAL;
                    end else begin
                        next_mode = cts_pkg::CTS_STANDBY;
                    end
                end
                cts_pkg::CTS_NORMAL: begin
                    if (standby_request_in_i) begin
                        next_mode = cts_pkg::CTS_STANDBY;
                    end
                end
                default: next_mode = cts_pkg::CTS_UNPOWERED;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode <= cts_pkg::CTS_UNPOWERED;
        end else if (ce_i) begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // wake-up phase filter
    // ------------------------------------------------------------
    // level only flips after a full filter time of the opposite level
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (ce_i && uv)) begin
            filt_dom <= 1'b0;
            filt_cnt <= '0;
        end else if (ce_i) begin
            if (wake_comparator_i == filt_dom) begin
                filt_cnt <= '0;
            end else if (filt_cnt == cts_pkg::FILTER_CYC - 16'h0001) begin
                filt_dom <= wake_comparator_i;
                filt_cnt <= '0;
            end else begin
                filt_cnt <= filt_cnt + 16'h0001;
            end
        end
    end

    assign filt_rise = (wake_comparator_i != filt_dom) && !filt_dom
                       && (filt_cnt == cts_pkg::FILTER_CYC - 16'h0001);
    assign filt_fall = (wake_comparator_i != filt_dom) && filt_dom
                       && (filt_cnt == cts_pkg::FILTER_CYC - 16'h0001);

    // ------------------------------------------------------------
    // wake-up pattern sequencer
    // ------------------------------------------------------------
    // only a fresh dominant edge starts a pattern, so a stuck bus never wakes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (ce_i && mode != cts_pkg::CTS_STANDBY)) begin
            wstate       <= cts_pkg::CTS_W_IDLE;
            wake_cnt     <= '0;
            wake_pending <= 1'b0;
        end else if (ce_i) begin
            if (wstate != cts_pkg::CTS_W_IDLE) begin
                wake_cnt <= wake_cnt + 16'h0001;
            end
            unique case (wstate)
                cts_pkg::CTS_W_IDLE: begin
                    wake_cnt <= '0;
                    if (filt_rise) begin
                        wstate <= cts_pkg::CTS_W_DOM1;
                    end
                end
                cts_pkg::CTS_W_DOM1,
                cts_pkg::CTS_W_REC: begin
                    if (wake_cnt >= cts_pkg::WAKE_TIMEOUT_CYC) begin
                        wstate <= cts_pkg::CTS_W_IDLE;
                    end else if (wstate == cts_pkg::CTS_W_DOM1 && filt_fall) begin
                        wstate <= cts_pkg::CTS_W_REC;
                    end else if (wstate == cts_pkg::CTS_W_REC && filt_rise) begin
                        wstate       <= cts_pkg::CTS_W_IDLE;
                        wake_pending <= 1'b1;
                    end
                end
                default: wstate <= cts_pkg::CTS_W_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // transmit dominant time-out
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dom_to       <= 1'b0;
            txd_low_cnt  <= '0;
            txd_high_cnt <= '0;
        end else if (ce_i) begin
            if (!txd_i) begin
                txd_high_cnt <= '0;
                if (txd_low_cnt < cts_pkg::DOMINANT_TO_CYC) begin
                    txd_low_cnt <= txd_low_cnt + 16'h0001;
                end else begin
                    dom_to <= 1'b1;
                end
            end else if (!dom_to) begin
                txd_low_cnt <= '0;
            end else if (txd_high_cnt == cts_pkg::TXD_RECOVER_CYC - 16'h0001) begin
                dom_to       <= 1'b0;
                txd_low_cnt  <= '0;
                txd_high_cnt <= '0;
            end else begin
                txd_high_cnt <= txd_high_cnt + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // overtemperature latch
    // ------------------------------------------------------------
    // the transmit-high term stops the driver chattering on thermal drift
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ot_latch <= 1'b0;
        end else if (ce_i) begin
            if (overtemp_i) begin
                ot_latch <= 1'b1;
            end else if (txd_i) begin
                ot_latch <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // receive clamp detection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            silent    <= 1'b0;
            clamp_cnt <= '0;
        end else if (ce_i) begin
            if (mode != cts_pkg::CTS_NORMAL || !rxd_pin_i) begin
                silent    <= 1'b0;
                clamp_cnt <= '0;
            end else if (bus_level_comparator_i) begin
                if (clamp_cnt < cts_pkg::CLAMP_DETECT_CYC) begin
                    clamp_cnt <= clamp_cnt + 16'h0001;
                end else begin
                    silent <= 1'b1;
                end
            end else begin
                clamp_cnt <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    assign next_drv_en = (next_mode == cts_pkg::CTS_NORMAL) && !silent
                         && !dom_to && !ot_latch && !overtemp_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            drv_enable_o       <= 1'b0;
            drv_dominant_o     <= 1'b0;
            hs_comp_enable_o   <= 1'b0;
            wake_comp_enable_o <= 1'b0;
            rxd_o              <= 1'b1;
            status_o           <= '{cts_pkg::CTS_UNPOWERED, 1'b0, 1'b0, 1'b0, 1'b0};
        end else if (ce_i) begin
            drv_enable_o       <= next_drv_en;
            drv_dominant_o     <= next_drv_en && !txd_i;
            hs_comp_enable_o   <= (next_mode == cts_pkg::CTS_NORMAL);
            wake_comp_enable_o <= !uv;
            if (mode == cts_pkg::CTS_NORMAL) begin
                rxd_o <= !bus_level_comparator_i;
            end else if (mode == cts_pkg::CTS_STANDBY) begin
                rxd_o <= !wake_pending;
            end else begin
                rxd_o <= 1'b1;
            end
            // mode field tracks the same edge as the driver and comparator enables
            status_o <= '{next_mode, silent, dom_to, ot_latch, wake_pending};
        end
    end

endmodule : cts_supervisor
`default_nettype wire

// ===== verification/cts_supervisor_chk.sv
// port-level assertions for the transceiver supervisor
`timescale 1ns/1ns
`default_nettype none
module cts_supervisor_chk (
    // clock, reset, controller side
    input wire logic clk_i, rst_n_i, ce_i, txd_i, standby_request_in_i, rxd_o,
    // monitors
    input wire logic vcc_uv_i, io_supply_uv_i, overtemp_i, bus_level_comparator_i,
    input wire logic wake_comparator_i, rxd_pin_i,
    // driver stage
    input wire logic drv_enable_o, drv_dominant_o, hs_comp_enable_o, wake_comp_enable_o,
    input wire cts_pkg::cts_status_t status_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [15:0] clamp_cnt;
    logic [15:0] low_cnt;
    wire logic   uv = vcc_uv_i || io_supply_uv_i;
    wire logic   nrm = status_o.mode == cts_pkg::CTS_NORMAL;

    // saturating run lengths, so the bounds below never wrap
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !nrm || !bus_level_comparator_i || !rxd_pin_i)
            clamp_cnt <= '0;
        else if (clamp_cnt != 16'hffff)
            clamp_cnt <= clamp_cnt + 16'h0001;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || txd_i)
            low_cnt <= '0;
        else if (low_cnt != 16'hffff)
            low_cnt <= low_cnt + 16'h0001;
    end

    AST_UV_OFF: assert property (uv |=> !drv_enable_o && !status_o.mode)
        else $error("transceiver not off in undervoltage");
    AST_WAKE_DET: assert property (rst_n_i && ce_i |=> wake_comp_enable_o == !$past(uv))
        else $error("wake detector enable wrong");
    AST_TXD_LOW: assert property (!nrm && !txd_i |=> !nrm)
        else $error("normal entered with transmit low");
    AST_GO_STANDBY_REQUEST_IN: assert property (ce_i && nrm && standby_request_in_i && !uv
        |=> status_o.mode == cts_pkg::CTS_STANDBY) else $error("standby request lost");
    AST_HOT: assert property (overtemp_i || (status_o.overtemp && !txd_i) |=> !drv_enable_o)
        else $error("drivers on while hot");
    AST_CLAMP: assert property (clamp_cnt >= cts_pkg::CLAMP_DETECT_CYC + 16'h0004
        |-> status_o.silent && !drv_enable_o) else $error("clamp not detected");
    AST_CLAMP_REL: assert property (!rxd_pin_i |-> ##2 !status_o.silent)
        else $error("silent not released");
    AST_DOM_TO: assert property (low_cnt >= cts_pkg::DOMINANT_TO_CYC + 16'h0004
        |-> !drv_dominant_o) else $error("bus held dominant past time-out");
    AST_WAKE_RXD: assert property (status_o.wake_pending && standby_request_in_i && !uv
        |=> !rxd_o) else $error("wake not signalled");
    AST_RXD_HIGH: assert property ((!status_o.wake_pending && status_o.mode ==
        cts_pkg::CTS_STANDBY) [*2] |-> rxd_o) else $error("receive low without wake");

    cover property (status_o.wake_pending);
    cover property (status_o.silent);
    cover property (status_o.dom_timeout);
    cover property (status_o.overtemp && !overtemp_i);
endmodule : cts_supervisor_chk
`default_nettype wire

// ===== verification/cts_ctrl_model.sv
// controller-side model: transmit data and standby request
`timescale 1ns/1ns
`default_nettype none
module cts_ctrl_model (
    // clock
    input  wire logic clk_i,
    // controller pins
    output var logic  txd_o,
    output var logic  standby_req_o
);
    // idle high, as the pull-ups would leave the pins
    initial begin
        txd_o  = 1'b1;
        standby_req_o = 1'b1;
    end
    task automatic drive(input logic txd, input logic standby);
        @(posedge clk_i);
        txd_o         <= txd;
        standby_req_o <= standby;
    endtask : drive
endmodule : cts_ctrl_model
`default_nettype wire

// ===== verification/tb_cts_supervisor.sv
// self-checking bench for the transceiver supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_cts_supervisor;
    logic clk_i, rst_n_i, txd, standby_req, rxd_o, vcc_uv, io_uv, ot, bus_cmp, wake_cmp, rxd_pin;
    logic clamp, drv_en, drv_dom, hs_en, wk_en, ce;
    cts_pkg::cts_status_t st;
    cts_pkg::cts_mode_t   m_mode;
    int                   err_count, checks, seed;

    cts_supervisor cts_supervisor_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .txd_i(txd), .standby_request_in_i(standby_req), .rxd_o(rxd_o), .vcc_uv_i(vcc_uv),
        .io_supply_uv_i(io_uv), .overtemp_i(ot), .bus_level_comparator_i(bus_cmp),
        .wake_comparator_i(wake_cmp), .rxd_pin_i(rxd_pin), .drv_enable_o(drv_en),
        .drv_dominant_o(drv_dom), .hs_comp_enable_o(hs_en), .wake_comp_enable_o(wk_en),
        .status_o(st));
    cts_ctrl_model cts_ctrl_model_i (.clk_i(clk_i), .txd_o(txd), .standby_req_o(standby_req));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // the receive pin follows the output unless the bench clamps it high
    always @(posedge clk_i) rxd_pin <= clamp | rxd_o;
    // -------------------------------------------------------------
    // reference mode model, compared every cycle
    // -------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i || vcc_uv || io_uv)
            m_mode <= cts_pkg::CTS_UNPOWERED;
        else if (!ce)
            m_mode <= m_mode;
        else if (m_mode == cts_pkg::CTS_NORMAL)
            m_mode <= standby_req ? cts_pkg::CTS_STANDBY : cts_pkg::CTS_NORMAL;
        else
            m_mode <= (!standby_req && txd) ? cts_pkg::CTS_NORMAL : cts_pkg::CTS_STANDBY;
    end
    always @(negedge clk_i) if (rst_n_i) check(st.mode, m_mode);

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic lv, input int n);
        wake_cmp <= lv;
        cyc(n);
    endtask : bus
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    initial begin
        cyc(40000);
        err_count++;
        print_verdict();
    end
    initial begin
        seed = 32'h563b;
        {ce, rst_n_i, vcc_uv, io_uv, ot, bus_cmp, wake_cmp, clamp, rxd_pin} = 9'h101;
        cyc(5);
        rst_n_i <= 1'b1;
        cts_ctrl_model_i.drive(1'b0, 1'b0);
        cyc(5);
        cts_ctrl_model_i.drive(1'b1, 1'b0);
        cyc(3);
        @(negedge clk_i) check({hs_en, drv_en}, 2'b11);
        cyc(1);
        {bus_cmp, clamp} <= 2'b11;
        cyc(cts_pkg::CLAMP_DETECT_CYC + 10);
        @(negedge clk_i) check({st.silent, drv_en}, 2'b10);
        cyc(1);
        clamp <= 1'b0;
        cyc(4);
        @(negedge clk_i) check({st.silent, drv_en}, 2'b01);
        cyc(1);
        bus_cmp <= 1'b0;
        cts_ctrl_model_i.drive(1'b0, 1'b0);
        cyc(cts_pkg::DOMINANT_TO_CYC - 10);
        @(negedge clk_i) check({st.dom_timeout, drv_dom}, 2'b01);
        cyc(20);
        @(negedge clk_i) check({st.dom_timeout, drv_dom}, 2'b10);
        cts_ctrl_model_i.drive(1'b1, 1'b0);
        cyc(cts_pkg::TXD_RECOVER_CYC - 10);
        @(negedge clk_i) check(2'(st.dom_timeout), 2'b01);
        cyc(15);
        @(negedge clk_i) check({st.dom_timeout, drv_en}, 2'b01);
        cts_ctrl_model_i.drive(1'b0, 1'b0);
        ot <= 1'b1;
        cyc(3);
        ot <= 1'b0;
        cyc(3);
        @(negedge clk_i) check({st.overtemp, drv_en}, 2'b10);
        cts_ctrl_model_i.drive(1'b1, 1'b0);
        cyc(3);
        @(negedge clk_i) check({st.overtemp, drv_en}, 2'b01);
        for (int i = 0; i < 2; i++) begin
            cyc(1);
            {vcc_uv, io_uv} <= i[0] ? 2'b01 : 2'b10;
            cts_ctrl_model_i.drive(1'b1, i[0]);
            cyc(3);
            @(negedge clk_i) check({wk_en, drv_en | ~rxd_o}, 2'b00);
            cyc(1);
            {vcc_uv, io_uv} <= 2'b00;
            cyc(3);
            @(negedge clk_i) check(2'(wk_en), 2'b01);
        end
        cyc(1);
        repeat (30) begin
            bus(1'b1, 1 + ($random(seed) & 31));
            bus(1'b0, 1 + ($random(seed) & 31));
        end
        // dominant far past the time-out: the pattern must die before any recessive
        bus(1'b1, 5000);
        bus(1'b0, 1000);
        @(negedge clk_i) check(2'(rxd_o), 2'b01);
        cyc(1);
        bus(1'b1, 100);
        bus(1'b0, cts_pkg::WAKE_TIMEOUT_CYC);
        bus(1'b1, 100);
        bus(1'b0, cts_pkg::WAKE_TIMEOUT_CYC + 100);
        @(negedge clk_i) check(2'(rxd_o), 2'b01);
        cyc(1);
        bus(1'b1, 70);
        bus(1'b0, 70);
        bus(1'b1, 70);
        @(negedge clk_i) check({rxd_o, hs_en}, 2'b00);
        cts_ctrl_model_i.drive(1'b1, 1'b0);
        cyc(3);
        @(negedge clk_i) check(2'(hs_en), 2'b01);
        // clock enable low: a standby request must not be taken until it returns
        cyc(1);
        ce <= 1'b0;
        cts_ctrl_model_i.drive(1'b1, 1'b1);
        cyc(3);
        @(negedge clk_i) check(2'(hs_en), 2'b01);
        cyc(1);
        ce <= 1'b1;
        cyc(3);
        @(negedge clk_i) check(2'(hs_en), 2'b00);
        print_verdict();
    end
endmodule : tb_cts_supervisor

bind cts_supervisor cts_supervisor_chk cts_supervisor_chk_i (.clk_i, .rst_n_i, .ce_i, .txd_i,
    .standby_request_in_i, .rxd_o, .vcc_uv_i, .io_supply_uv_i, .overtemp_i,
    .bus_level_comparator_i, .wake_comparator_i, .rxd_pin_i, .drv_enable_o, .drv_dominant_o,
    .hs_comp_enable_o, .wake_comp_enable_o, .status_o);
`default_nettype wire
